// [include/pmm_pkg.sv]
// package: constants, register map and modes of the power mode manager
package pmm_pkg;
  // ==========================================================
  // register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_POWER_MODE_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_SUPPLY_MONITOR_CONTROL = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_ACTIVE_CLOCK_CONTROL = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_PERIPHERAL_CLOCK_POWERDOWN = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_RESET_CAUSE_STATUS = 8'h40;
  localparam logic [ADDR_W-1:0] ADDR_SRAM_RETENTION_CONTROL = 8'h78;
  localparam logic [ADDR_W-1:0] ADDR_SHUTDOWN_ACK = 8'h7c;
  // ==========================================================
  // fields and reset values
  localparam int SEL_W = 3;
  localparam int ACK_BIT = 3;
  localparam int MON_DIS_BIT = 1;
  localparam int MON_LOW_BIT = 0;
  localparam logic [SEL_W-1:0] SEL_FLEXI = 3'h0;
  localparam logic [SEL_W-1:0] SEL_HIBERNATE = 3'h5;
  localparam logic [SEL_W-1:0] SEL_SHUTDOWN = 3'h6;
  localparam logic [1:0] MON_CTRL_RESET = 2'h3;
  localparam logic RETAIN_RESET = 1'h1;
  localparam logic [7:0] CLK_DIV_RESET = 8'h00;
  localparam logic [7:0] PCLK_GATE_RESET = 8'h00;
  localparam logic [1:0] CAUSE_POR = 2'h1;
  localparam logic [1:0] CAUSE_SHUTDOWN_WAKE = 2'h2;
  // wake lines, and the three of them usable from shutdown
  localparam int WAKE_LINES = 9;
  localparam int SD_WAKE_A = 0;
  localparam int SD_WAKE_B = 1;
  localparam int SD_WAKE_C = 8;
  // ==========================================================
  // timing
  localparam int CLK_MHZ = 250;
  localparam int POR_HOLD_MS = 48;
  localparam int POR_HOLD_CYC = POR_HOLD_MS * 1000 * CLK_MHZ;
  localparam int FLEXI_WAKE_MAX_CYC = 5;
  localparam int HIB_WAKE_US = 10;
  localparam int HIB_WAKE_CYC = HIB_WAKE_US * CLK_MHZ;
  localparam int CORE_CLK_MHZ = 16;
  // ==========================================================
  // modes, one-hot
  typedef enum logic [5:0] {
    PMM_POR     = 6'h01,
    PMM_ACTIVE  = 6'h02,
    PMM_FLEXI   = 6'h04,
    PMM_HIB     = 6'h08,
    PMM_SHUT    = 6'h10,
    PMM_WAKE    = 6'h20
  } pmm_mode_t;
endpackage : pmm_pkg

// [rtl/pmm_delay.sv]
// down counter that signals when a loaded delay has elapsed
`timescale 1ns/10ps
`default_nettype none
module pmm_delay #(
  parameter int CNT_W = 24
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic load_i,
  input wire logic [CNT_W-1:0] count_i,
  output logic done_o
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic run;
  } pmm_dly_t;
  pmm_dly_t st_reg;
  pmm_dly_t st_next;

  // ==========================================================
  // counting; done is a level while the count is idle
  always_comb
  begin
    st_next = st_reg;
    if (load_i)
    begin
      st_next.cnt = count_i;
      st_next.run = 1'b1;
    end
    else if (st_reg.run)
    begin
      if (st_reg.cnt <= 1)
        st_next.run = 1'b0;
      else
        st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign done_o = ~st_reg.run & ~load_i;
endmodule : pmm_delay
`default_nettype wire

// [rtl/pmm_top.sv]
// power mode manager: mode sequencing, supply monitor, register file
//
// Functional notes
// - hold core reset about 48 ms after power-on
// - low supply raises nonmaskable interrupt
// - monitor disable bit suppresses interrupt
// - monitor off in shutdown, wakes hibernate/flexi
// - always start and wake into active
// - core clock 16 MHz, divider, gates
// - flexi: core light sleep, peripherals run
// - flexi wakes on any interrupt, five cycles
// - hibernate: fast oscillator and clocks off
// - hibernate: slow oscillator, watchdog, pins held
// - hibernate keeps all SRAM, or half
// - hibernate wakes on pin, timer, watchdog
// - regulators follow the mode automatically
// - shutdown: only pads kept, all off
// - shutdown wakes only on lines 0,1,8
// - shutdown wake acts as power-up
// - shutdown ack records waking line
// - mode field: 000, 101, 110
// - deep sleep ready ack at bit 3
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module pmm_top
  import pmm_pkg::*;
#(
  parameter int POR_CYC = pmm_pkg::POR_HOLD_CYC,
  parameter int HIB_CYC = pmm_pkg::HIB_WAKE_CYC
) (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  // register port
  input wire logic [pmm_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [pmm_pkg::DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [pmm_pkg::DATA_W-1:0] RDATA_O,
  // core side
  input wire logic SLEEP_REQ_I,
  input wire logic DEEP_SLEEP_REQ_I,
  input wire logic CORE_DS_READY_I,
  input wire logic IRQ_ANY_I,
  input wire logic [pmm_pkg::WAKE_LINES-1:0] EXT_IRQ_I,
  input wire logic WAKE_TIMER_IRQ_I,
  input wire logic WATCHDOG_IRQ_I,
  input wire logic SUPPLY_LOW_I,
  output logic CORE_RESET_N_O,
  output logic CORE_CLK_EN_O,
  output logic CORE_DEEP_SLEEP_O,
  output logic SUPPLY_NMI_O,
  // clock, regulator and memory controls
  output logic FAST_OSC_EN_O,
  output logic SLOW_OSC_EN_O,
  output logic SYS_CLK_EN_O,
  output logic [7:0] CLK_DIV_O,
  output logic [7:0] PCLK_GATE_O,
  output logic HP_REG_EN_O,
  output logic LP_REG_EN_O,
  output logic SRAM_LOW_RET_O,
  output logic SRAM_HIGH_RET_O,
  output logic PAD_HOLD_O,
  output logic WATCHDOG_EN_O,
  output logic SUPPLY_MON_EN_O
);
  typedef struct packed {
    pmm_mode_t mode;
    logic [SEL_W-1:0] low_power_select;
    logic [1:0] monitor_ctrl;
    logic retain_all;
    logic [7:0] clk_div;
    logic [7:0] pclk_gate;
    logic [1:0] reset_cause;
    logic [2:0] shutdown_ack;
    logic [DATA_W-1:0] rdata;
    logic core_rst_n;
    logic core_clk;
    logic deep_sleep;
    logic nmi;
    logic fast_osc;
    logic slow_osc;
    logic sys_clk;
    logic hp_reg;
    logic lp_reg;
    logic sram_lo;
    logic sram_hi;
    logic pad_hold;
    logic mon_en;
    logic [2:0] fwake;
    logic dly_load;
    logic [31:0] dly_cnt;
  } pmm_state_t;

  pmm_state_t st_reg;
  pmm_state_t st_next;
  logic rst_s1_reg;
  logic rst_n;
  logic dly_done;
  logic sd_wake;

  // ==========================================================
  // reset release through two flops
  always_ff @(posedge MCLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  // ==========================================================
  // delay counter for power-up and hibernate wake
  pmm_delay #(.CNT_W(32)) u_delay (
    .clk_i(MCLK_I),
    .rst_n_i(rst_n),
    .load_i(st_reg.dly_load),
    .count_i(st_reg.dly_cnt),
    .done_o(dly_done)
  );

  // only lines 0, 1 and 8 wake from shutdown
  assign sd_wake = EXT_IRQ_I[SD_WAKE_A] | EXT_IRQ_I[SD_WAKE_B] | EXT_IRQ_I[SD_WAKE_C];

  // ==========================================================
  // next state: registers, mode sequencing, outputs
  always_comb
  begin
    st_next = st_reg;
    st_next.dly_load = 1'b0;
    st_next.rdata = '0;
    // register writes
    if (WR_I)
    begin
      case (ADDR_I)
        ADDR_POWER_MODE_CONTROL: st_next.low_power_select = WDATA_I[SEL_W-1:0];
        ADDR_SUPPLY_MONITOR_CONTROL: st_next.monitor_ctrl[MON_DIS_BIT] = WDATA_I[MON_DIS_BIT];
        ADDR_ACTIVE_CLOCK_CONTROL: st_next.clk_div = WDATA_I[7:0];
        ADDR_PERIPHERAL_CLOCK_POWERDOWN: st_next.pclk_gate = WDATA_I[7:0];
        ADDR_SRAM_RETENTION_CONTROL: st_next.retain_all = WDATA_I[0];
        default: st_next.low_power_select = st_reg.low_power_select;
      endcase
    end
    // register reads; data stand one cycle later
    if (RD_I)
    begin
      case (ADDR_I)
        ADDR_POWER_MODE_CONTROL:
          st_next.rdata = {12'h000, CORE_DS_READY_I, st_reg.low_power_select};
        ADDR_SUPPLY_MONITOR_CONTROL: st_next.rdata = {14'h0000, st_reg.monitor_ctrl};
        ADDR_ACTIVE_CLOCK_CONTROL: st_next.rdata = {8'h00, st_reg.clk_div};
        ADDR_PERIPHERAL_CLOCK_POWERDOWN: st_next.rdata = {8'h00, st_reg.pclk_gate};
        ADDR_RESET_CAUSE_STATUS: st_next.rdata = {14'h0000, st_reg.reset_cause};
        ADDR_SRAM_RETENTION_CONTROL: st_next.rdata = {15'h0000, st_reg.retain_all};
        ADDR_SHUTDOWN_ACK: st_next.rdata = {13'h0000, st_reg.shutdown_ack};
        default: st_next.rdata = '0;
      endcase
    end
    // supply monitor: low indication is sampled live
    st_next.monitor_ctrl[MON_LOW_BIT] = SUPPLY_LOW_I;
    // mode sequencing
    case (st_reg.mode)
      PMM_POR:
      begin
        if (dly_done)
          st_next.mode = PMM_ACTIVE;
      end
      PMM_ACTIVE:
      begin
        if (SLEEP_REQ_I && !DEEP_SLEEP_REQ_I && st_reg.low_power_select == SEL_FLEXI)
          st_next.mode = PMM_FLEXI;
        else if (DEEP_SLEEP_REQ_I && CORE_DS_READY_I)
        begin
          if (st_reg.low_power_select == SEL_HIBERNATE)
            st_next.mode = PMM_HIB;
          else if (st_reg.low_power_select == SEL_SHUTDOWN)
            st_next.mode = PMM_SHUT;
        end
        st_next.fwake = '0;
      end
      PMM_FLEXI:
      begin
        // any interrupt or supply alarm wakes; core runs again next cycle
        if (IRQ_ANY_I || st_reg.nmi)
          st_next.mode = PMM_ACTIVE;
      end
      PMM_HIB:
      begin
        if (|EXT_IRQ_I || WAKE_TIMER_IRQ_I || WATCHDOG_IRQ_I || st_reg.nmi)
        begin
          st_next.mode = PMM_WAKE;
          st_next.dly_load = 1'b1;
          st_next.dly_cnt = 32'(HIB_CYC);
        end
      end
      PMM_SHUT:
      begin
        if (sd_wake)
        begin
          // behaves as a full power-up
          st_next.mode = PMM_POR;
          st_next.dly_load = 1'b1;
          st_next.dly_cnt = 32'(POR_CYC);
          st_next.reset_cause = CAUSE_POR;
          st_next.shutdown_ack = {EXT_IRQ_I[SD_WAKE_C], EXT_IRQ_I[SD_WAKE_B],
                                  EXT_IRQ_I[SD_WAKE_A]};
          st_next.low_power_select = SEL_FLEXI;
          st_next.clk_div = CLK_DIV_RESET;
          st_next.pclk_gate = PCLK_GATE_RESET;
          st_next.monitor_ctrl[MON_DIS_BIT] = MON_CTRL_RESET[MON_DIS_BIT];
          st_next.retain_all = RETAIN_RESET;
        end
      end
      PMM_WAKE:
      begin
        if (dly_done && !st_reg.dly_load)
          st_next.mode = PMM_ACTIVE;
      end
      default: st_next.mode = PMM_ACTIVE;
    endcase
    // per-mode resources, taken from the next mode so outputs move with it
    st_next.core_rst_n = (st_next.mode != PMM_POR) && (st_next.mode != PMM_SHUT);
    st_next.core_clk = (st_next.mode == PMM_ACTIVE);
    st_next.deep_sleep = (st_next.mode == PMM_HIB) || (st_next.mode == PMM_WAKE);
    st_next.fast_osc = (st_next.mode == PMM_ACTIVE) || (st_next.mode == PMM_FLEXI)
                       || (st_next.mode == PMM_POR);
    st_next.sys_clk = st_next.fast_osc;
    st_next.slow_osc = (st_next.mode != PMM_SHUT);
    st_next.hp_reg = st_next.fast_osc;
    st_next.lp_reg = st_next.deep_sleep;
    st_next.sram_lo = (st_next.mode != PMM_SHUT);
    st_next.sram_hi = (st_next.mode != PMM_SHUT)
                      && (!st_next.deep_sleep || st_reg.retain_all);
    st_next.pad_hold = st_next.deep_sleep || (st_next.mode == PMM_SHUT);
    st_next.mon_en = (st_next.mode != PMM_SHUT);
    // interrupt follows the next mode, so it never outlives the monitor's power
    st_next.nmi = SUPPLY_LOW_I & ~st_reg.monitor_ctrl[MON_DIS_BIT]
                  & (st_next.mode != PMM_SHUT) & (st_next.mode != PMM_POR);
  end

  // ==========================================================
  // state register; power-up delay starts right after release
  always_ff @(posedge MCLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
      st_reg.mode <= PMM_POR;
      st_reg.low_power_select <= SEL_FLEXI;
      st_reg.monitor_ctrl <= MON_CTRL_RESET;
      st_reg.retain_all <= RETAIN_RESET;
      st_reg.clk_div <= CLK_DIV_RESET;
      st_reg.pclk_gate <= PCLK_GATE_RESET;
      st_reg.reset_cause <= CAUSE_POR;
      st_reg.fast_osc <= 1'b1;
      st_reg.sys_clk <= 1'b1;
      st_reg.slow_osc <= 1'b1;
      st_reg.hp_reg <= 1'b1;
      st_reg.sram_lo <= 1'b1;
      st_reg.sram_hi <= 1'b1;
      st_reg.dly_load <= 1'b1;
      st_reg.dly_cnt <= 32'(POR_CYC);
    end
    else
      st_reg <= st_next;
  end

  // ==========================================================
  // outputs straight from the state register
  assign RDATA_O = st_reg.rdata;
  assign CORE_RESET_N_O = st_reg.core_rst_n;
  assign CORE_CLK_EN_O = st_reg.core_clk;
  assign CORE_DEEP_SLEEP_O = st_reg.deep_sleep;
  assign SUPPLY_NMI_O = st_reg.nmi;
  assign FAST_OSC_EN_O = st_reg.fast_osc;
  assign SLOW_OSC_EN_O = st_reg.slow_osc;
  assign SYS_CLK_EN_O = st_reg.sys_clk;
  assign CLK_DIV_O = st_reg.clk_div;
  assign PCLK_GATE_O = st_reg.pclk_gate;
  assign HP_REG_EN_O = st_reg.hp_reg;
  assign LP_REG_EN_O = st_reg.lp_reg;
  assign SRAM_LOW_RET_O = st_reg.sram_lo;
  assign SRAM_HIGH_RET_O = st_reg.sram_hi;
  assign PAD_HOLD_O = st_reg.pad_hold;
  assign WATCHDOG_EN_O = st_reg.slow_osc;
  assign SUPPLY_MON_EN_O = st_reg.mon_en;
endmodule : pmm_top
`default_nettype wire

// [tb/pmm_monitor.sv]
// checker: mode, power and wake relations at the manager's ports
`timescale 1ns/10ps
`default_nettype none
module pmm_monitor #(
  parameter int POR_CYC = 20
) (
  // clock, reset and core side
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  input wire logic SLEEP_REQ_I,
  input wire logic DEEP_SLEEP_REQ_I,
  input wire logic CORE_DS_READY_I,
  input wire logic IRQ_ANY_I,
  input wire logic [8:0] EXT_IRQ_I,
  input wire logic CORE_RESET_N_O,
  input wire logic CORE_CLK_EN_O,
  input wire logic CORE_DEEP_SLEEP_O,
  input wire logic SUPPLY_NMI_O,
  // power controls
  input wire logic FAST_OSC_EN_O,
  input wire logic SLOW_OSC_EN_O,
  input wire logic SYS_CLK_EN_O,
  input wire logic HP_REG_EN_O,
  input wire logic LP_REG_EN_O,
  input wire logic SRAM_LOW_RET_O,
  input wire logic PAD_HOLD_O,
  input wire logic SUPPLY_MON_EN_O
);
  int hold_cnt;
  // ==========================================
  // core hold count, cleared in shutdown so a wake restarts it
  always_ff @(posedge MCLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      hold_cnt <= 0;
    end
    else
    begin
      hold_cnt <= (CORE_RESET_N_O || !SLOW_OSC_EN_O) ? 0 : hold_cnt + 1;
    end
  end
  default clocking @(posedge MCLK_I);
  endclocking
  default disable iff (!RESETN_I);
  // ==========================================
  // assertions
  AST_REG_PAIR: assert property (!(HP_REG_EN_O && LP_REG_EN_O))
    else $error("both regulator sets on");
  AST_CLK_SOURCE: assert property (SYS_CLK_EN_O |-> FAST_OSC_EN_O && HP_REG_EN_O)
    else $error("system clock without its source");
  AST_HIB_STATE: assert property (CORE_DEEP_SLEEP_O |-> !CORE_CLK_EN_O && !FAST_OSC_EN_O
    && !SYS_CLK_EN_O && SLOW_OSC_EN_O && LP_REG_EN_O && SRAM_LOW_RET_O && PAD_HOLD_O)
    else $error("deep sleep controls wrong");
  AST_SHUT_STATE: assert property (!SLOW_OSC_EN_O |-> !FAST_OSC_EN_O && !HP_REG_EN_O
    && !LP_REG_EN_O && !SRAM_LOW_RET_O && !SUPPLY_MON_EN_O && PAD_HOLD_O)
    else $error("shutdown controls wrong");
  AST_NMI_POWERED: assert property (SUPPLY_NMI_O |-> SUPPLY_MON_EN_O && CORE_RESET_N_O)
    else $error("supply interrupt while monitor off");
  AST_FLEXI_WAKE: assert property (CORE_RESET_N_O && SYS_CLK_EN_O && !CORE_CLK_EN_O
    && IRQ_ANY_I |-> ##[1:5] CORE_CLK_EN_O)
    else $error("light sleep wake too slow");
  AST_STAY_ACTIVE: assert property (CORE_CLK_EN_O && !SLEEP_REQ_I && !DEEP_SLEEP_REQ_I
    |=> CORE_CLK_EN_O)
    else $error("core clock dropped without request");
  AST_DEEP_ENTRY: assert property ($rose(CORE_DEEP_SLEEP_O) || $fell(SLOW_OSC_EN_O)
    |-> ($past(DEEP_SLEEP_REQ_I) || $past(DEEP_SLEEP_REQ_I, 2))
    && ($past(CORE_DS_READY_I) || $past(CORE_DS_READY_I, 2)))
    else $error("deep mode entered without ready request");
  AST_SHUT_HOLD: assert property (!SLOW_OSC_EN_O && ((EXT_IRQ_I | $past(EXT_IRQ_I)
    | $past(EXT_IRQ_I, 2)) & 9'h103) == 9'h000 |=> !SLOW_OSC_EN_O)
    else $error("shutdown left without wake line");
  AST_POR_HOLD: assert property ($rose(CORE_RESET_N_O)
    |-> hold_cnt inside {[POR_CYC:POR_CYC + 8]})
    else $error("core reset hold length wrong");
endmodule : pmm_monitor
bind pmm_top pmm_monitor #(.POR_CYC(POR_CYC)) u_mon (
  .MCLK_I(MCLK_I), .RESETN_I(RESETN_I), .SLEEP_REQ_I(SLEEP_REQ_I),
  .DEEP_SLEEP_REQ_I(DEEP_SLEEP_REQ_I), .CORE_DS_READY_I(CORE_DS_READY_I),
  .IRQ_ANY_I(IRQ_ANY_I), .EXT_IRQ_I(EXT_IRQ_I), .CORE_RESET_N_O(CORE_RESET_N_O),
  .CORE_CLK_EN_O(CORE_CLK_EN_O), .CORE_DEEP_SLEEP_O(CORE_DEEP_SLEEP_O),
  .SUPPLY_NMI_O(SUPPLY_NMI_O), .FAST_OSC_EN_O(FAST_OSC_EN_O), .SLOW_OSC_EN_O(SLOW_OSC_EN_O),
  .SYS_CLK_EN_O(SYS_CLK_EN_O), .HP_REG_EN_O(HP_REG_EN_O), .LP_REG_EN_O(LP_REG_EN_O),
  .SRAM_LOW_RET_O(SRAM_LOW_RET_O), .PAD_HOLD_O(PAD_HOLD_O), .SUPPLY_MON_EN_O(SUPPLY_MON_EN_O)
);
`default_nettype wire

// [tb/pmm_core_model.sv]
// core model: sleep requests, deep sleep readiness and interrupts
`timescale 1ns/10ps
`default_nettype none
module pmm_core_model #(
  parameter int READY_LAT = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // commands from the bench
  input wire logic sleep_i,
  input wire logic deep_i,
  input wire logic force_i,
  input wire logic prep_i,
  input wire logic irq_i,
  // towards the manager
  output logic sleep_req_o,
  output logic deep_req_o,
  output logic ready_o,
  output logic irq_o
);
  logic [3:0] wait_reg;
  // readiness lags preparation, so a hasty request would be lost
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wait_reg <= 4'h0;
      ready_o <= 1'b0;
      sleep_req_o <= 1'b0;
      deep_req_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      wait_reg <= (prep_i && wait_reg < 4'(READY_LAT)) ? wait_reg + 4'h1 : {4{prep_i}} & wait_reg;
      ready_o <= prep_i && wait_reg == 4'(READY_LAT);
      sleep_req_o <= sleep_i;
      deep_req_o <= deep_i && (ready_o || force_i);
      irq_o <= irq_i;
    end
  end
endmodule : pmm_core_model
`default_nettype wire

// [tb/pmm_top_bench.sv]
// testbench: reset, register, light sleep, deep sleep and shutdown runs
`timescale 1ns/10ps
`default_nettype none
module pmm_top_bench;
  import pmm_pkg::*;
  // ==========================================
  // signals
  localparam int POR = 20;
  localparam int HIB = 10;
  logic mclk = 1'b0;
  logic rst_n, wr, rd, slp, dsl, rdy, irq, tmr, wdg, low, m_prep, m_irq;
  logic crst_n, cclk, cdeep, nmi, fast, slow, sysc, hp, lp, slo, shi, pad, wd, mon;
  logic [2:0] cmd;
  logic [7:0] addr, div, gate;
  logic [8:0] ext;
  logic [15:0] wdata, rdata, st;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  // packed view of the power controls
  assign st = {4'h0, fast, slow, sysc, hp, lp, slo, shi, pad, wd, mon, cdeep, cclk};
  always #2 mclk = ~mclk;
  pmm_top #(.POR_CYC(POR), .HIB_CYC(HIB)) u_dut (
    .MCLK_I(mclk), .RESETN_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .SLEEP_REQ_I(slp), .DEEP_SLEEP_REQ_I(dsl), .CORE_DS_READY_I(rdy),
    .IRQ_ANY_I(irq), .EXT_IRQ_I(ext), .WAKE_TIMER_IRQ_I(tmr), .WATCHDOG_IRQ_I(wdg),
    .SUPPLY_LOW_I(low), .CORE_RESET_N_O(crst_n), .CORE_CLK_EN_O(cclk),
    .CORE_DEEP_SLEEP_O(cdeep), .SUPPLY_NMI_O(nmi), .FAST_OSC_EN_O(fast), .SLOW_OSC_EN_O(slow),
    .SYS_CLK_EN_O(sysc), .CLK_DIV_O(div), .PCLK_GATE_O(gate), .HP_REG_EN_O(hp),
    .LP_REG_EN_O(lp), .SRAM_LOW_RET_O(slo), .SRAM_HIGH_RET_O(shi), .PAD_HOLD_O(pad),
    .WATCHDOG_EN_O(wd), .SUPPLY_MON_EN_O(mon));
  pmm_core_model u_core (
    .clk_i(mclk), .rst_n_i(rst_n), .sleep_i(cmd[0]), .deep_i(cmd[1]), .force_i(cmd[2]),
    .prep_i(m_prep), .irq_i(m_irq), .sleep_req_o(slp), .deep_req_o(dsl), .ready_o(rdy),
    .irq_o(irq));
  // ==========================================
  // tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] x);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    check(rdata, x);
  endtask : rd_chk
  // one-cycle core command, then let the mode change land
  task automatic pulse(input logic [2:0] c);
    @(posedge mclk);
    cmd <= c;
    @(posedge mclk);
    cmd <= 3'h0;
    repeat (3) @(negedge mclk);
  endtask : pulse
  task automatic prep(input logic v);
    @(posedge mclk);
    m_prep <= v;
    {ext, tmr, wdg, m_irq} <= '0;
    repeat (6) @(negedge mclk);
  endtask : prep
  task automatic wait_hi(input logic sel, output int k);
    k = 0;
    while ((sel ? crst_n : cclk) !== 1'b1 && k < 200)
    begin
      @(negedge mclk);
      k++;
    end
  endtask : wait_hi
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // hang guard, far above the few hundred cycles needed
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end
  // ==========================================
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    {wr, rd, cmd, m_prep, m_irq, tmr, wdg, low, addr, wdata, ext} = '0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    wait_hi(1'b1, n);
    check(16'(n >= POR), 16'h0001);
    rd_chk(ADDR_POWER_MODE_CONTROL, 16'h0000);
    rd_chk(ADDR_SUPPLY_MONITOR_CONTROL, 16'h0002);
    rd_chk(ADDR_RESET_CAUSE_STATUS, {14'h0, CAUSE_POR});
    rd_chk(ADDR_SHUTDOWN_ACK, 16'h0000);
    check(st, 16'h0f6d);
    wr_reg(ADDR_ACTIVE_CLOCK_CONTROL, 16'h0003);
    wr_reg(ADDR_PERIPHERAL_CLOCK_POWERDOWN, 16'h00a5);
    wr_reg(8'h20, 16'hffff);
    rd_chk(8'h20, 16'h0000);
    check({div, gate}, 16'h03a5);
    @(posedge mclk);
    low <= 1'b1;
    repeat (4) @(negedge mclk);
    check({15'h0, nmi}, 16'h0000);
    wr_reg(ADDR_SUPPLY_MONITOR_CONTROL, 16'h0000);
    rd_chk(ADDR_SUPPLY_MONITOR_CONTROL, 16'h0001);
    check({15'h0, nmi}, 16'h0001);
    wr_reg(ADDR_SUPPLY_MONITOR_CONTROL, 16'h0002);
    repeat (3) @(negedge mclk);
    check({15'h0, nmi}, 16'h0000);
    @(posedge mclk);
    low <= 1'b0;
    // light sleep and its fast wake
    wr_reg(ADDR_POWER_MODE_CONTROL, 16'h0000);
    pulse(3'h1);
    check(st, 16'h0f6c);
    @(posedge mclk);
    m_irq <= 1'b1;
    wait_hi(1'b0, n);
    check(16'(n <= 6), 16'h0001);
    prep(1'b0);
    // plain sleep with a deep select, and deep request before ready
    wr_reg(ADDR_POWER_MODE_CONTROL, 16'h0005);
    pulse(3'h1);
    pulse(3'h6);
    check(st, 16'h0f6d);
    // deep sleep with half retention, pin, timer and watchdog wake once each
    wr_reg(ADDR_SRAM_RETENTION_CONTROL, 16'h0000);
    for (int s = 0; s < 3; s++)
    begin
      prep(1'b1);
      rd_chk(ADDR_POWER_MODE_CONTROL, 16'h000d);
      pulse(3'h2);
      @(posedge mclk);
      m_irq <= 1'b1;
      repeat (6) @(negedge mclk);
      check(st, 16'h04de);
      @(posedge mclk);
      m_irq <= 1'b0;
      ext <= (s == 0) ? 9'h010 : 9'h000;
      tmr <= (s == 1);
      wdg <= (s == 2);
      wait_hi(1'b0, n);
      check(16'(n >= HIB && n <= HIB + 8), 16'h0001);
      prep(1'b0);
    end
    // shutdown, refused sources, then lines 0, 1 and 8
    for (int s = 0; s < 3; s++)
    begin
      wr_reg(ADDR_POWER_MODE_CONTROL, 16'h0006);
      prep(1'b1);
      rd_chk(ADDR_POWER_MODE_CONTROL, 16'h000e);
      pulse(3'h2);
      @(posedge mclk);
      {ext, tmr, wdg, m_irq, low} <= {9'h0f4, 4'hf};
      repeat (6) @(negedge mclk);
      check(st, 16'h0010);
      @(posedge mclk);
      ext <= 9'h001 << ((s == 2) ? 8 : s);
      low <= 1'b0;
      prep(1'b0);
      wait_hi(1'b0, n);
      check(st, 16'h0f6d);
      rd_chk(ADDR_SHUTDOWN_ACK, 16'h0001 << s);
      rd_chk(ADDR_RESET_CAUSE_STATUS, {14'h0, CAUSE_POR});
      rd_chk(ADDR_SRAM_RETENTION_CONTROL, 16'h0001);
    end
    tally_and_finish();
  end
endmodule : pmm_top_bench
`default_nettype wire
